// ==== src/cfg_word_loader.sv ====
// Purpose: reload configuration shadows from flash after every reset, decode security word
// Assumes: flash read port answers with rdata valid on a one-cycle ack
// Notes: registers read-only over apb except the alternate vector enable
//
// Contract
// - every reset restarts the copy of all flash configuration words
// - words are fetched from fixed addresses in the last flash page
// - oscillator and watchdog words drive power-on settings; protect bits gate access
// - alternate vector disable set forces alternate vector enable off and unwritable
// - config segment level: 111 none, 110 standard, 10x enhanced, 0xx high
// - config segment write-protect bit zero blocks writes to that segment
// - general segment level: 11 none, 10 standard, 0x high
// - general segment write-protect bit zero blocks writes to that segment
// - boot control bit one means no boot segment, else size from limit
// - boot segment level: 11 none, 10 standard, 0x high
// - boot limit holds inverted page after boot; all ones means size zero
// - boot write-protect bit zero blocks writes to the boot segment
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`include "cfg_loader_defines.svh"
module cfg_word_loader
    import cfg_loader_pkg::*;
#(
    parameter int WORDS = `CFG_WORD_COUNT
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    output logic FLASH_REQ_O,
    output logic [`CFG_FLASH_AW-1:0] FLASH_ADDR_O,
    input wire logic FLASH_ACK_I,
    input wire logic [`CFG_FLASH_DW-1:0] FLASH_RDATA_I,
    output logic SYS_RST_N_O,
    output logic [`CFG_WORD_W-1:0] OSC_SELECT_O,
    output logic [`CFG_WORD_W-1:0] OSC_CONFIG_O,
    output logic [`CFG_WORD_W-1:0] WATCHDOG_O,
    output logic ALT_VEC_ENABLE_O,
    output logic CFG_WRITE_BLOCK_O,
    output logic GEN_WRITE_BLOCK_O,
    output logic BOOT_WRITE_BLOCK_O,
    output logic [1:0] CFG_PROT_LEVEL_O,
    output logic [1:0] GEN_PROT_LEVEL_O,
    output logic [1:0] BOOT_PROT_LEVEL_O,
    output logic BOOT_SEG_PRESENT_O,
    output logic [`BOOT_LIM_HI:0] BOOT_SEG_END_PAGE_O,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [`APB_AW-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O
);
    load_state_type state;
    load_state_type next_state;
    logic [`CFG_IDX_W-1:0] idx;
    logic [`CFG_FLASH_DW-1:0] captured;
    logic upper_nonzero;
    logic alt_vec_enable;
    logic wr_en;
    logic [`CFG_IDX_W-1:0] rd_idx;
    logic [`CFG_WORD_W-1:0] rd_word;
    logic [WORDS*`CFG_WORD_W-1:0] words;
    logic [`CFG_WORD_W-1:0] sec_word;
    logic [`CFG_WORD_W-1:0] lim_word;
    logic load_done;
    logic apb_access;
    logic apb_wr;
    logic apb_rd;
    logic rd_shadow;
    logic rd_shadow_q;
    logic [31:0] rd_other_q;
    logic err_q;
    prot_level_type cfg_lvl;
    prot_level_type gen_lvl;
    prot_level_type boot_lvl;

    function automatic logic [`CFG_FLASH_AW-1:0] word_addr(input logic [`CFG_IDX_W-1:0] i);
        case (i)
            4'h0: word_addr = `CFG_ADDR_SECURITY;
            4'h1: word_addr = `CFG_ADDR_BOOT_LIMIT;
            4'h2: word_addr = `CFG_ADDR_SIGNATURE;
            4'h3: word_addr = `CFG_ADDR_OSC_SELECT;
            4'h4: word_addr = `CFG_ADDR_OSC_CONFIG;
            4'h5: word_addr = `CFG_ADDR_WATCHDOG;
            4'h6: word_addr = `CFG_ADDR_POWER_ON;
            4'h7: word_addr = `CFG_ADDR_DEBUG;
            4'h8: word_addr = `CFG_ADDR_DM_IVL_LO;
            4'h9: word_addr = `CFG_ADDR_DM_IVL_HI;
            4'ha: word_addr = `CFG_ADDR_DM_CNT_LO;
            4'hb: word_addr = `CFG_ADDR_DM_CNT_HI;
            4'hc: word_addr = `CFG_ADDR_DEADMAN;
            4'hd: word_addr = `CFG_ADDR_DEV_OPT;
            default: word_addr = `CFG_ADDR_SECURITY;
        endcase
    endfunction

    // two-bit level fields share one encoding
    function automatic prot_level_type level2(input logic [1:0] f);
        if (f == 2'b11) begin
            level2 = PROT_NONE;
        end else if (f == 2'b10) begin
            level2 = PROT_STANDARD;
        end else begin
            level2 = PROT_HIGH;
        end
    endfunction

    // loader sequencer; the async reset restarts it on any reset source
    always_comb begin
        next_state = state;
        case (state)
            LOAD_IDLE: next_state = LOAD_READ;
            LOAD_READ: begin
                if (FLASH_ACK_I) begin
                    next_state = LOAD_CAPTURE;
                end
            end
            LOAD_CAPTURE: begin
                if (idx == `IDX_LAST) begin
                    next_state = LOAD_DONE;
                end else begin
                    next_state = LOAD_READ;
                end
            end
            LOAD_DONE: next_state = LOAD_DONE;
            default: next_state = LOAD_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= LOAD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            idx <= '0;
        end else if (state == LOAD_CAPTURE && idx != `IDX_LAST) begin
            idx <= idx + 4'h1;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            captured <= '0;
        end else if (state == LOAD_READ && FLASH_ACK_I) begin
            captured <= FLASH_RDATA_I;
        end
    end

    // upper byte carries no bits; nonzero is only flagged for software
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            upper_nonzero <= 1'b0;
        end else if (wr_en && captured[`CFG_UPPER_BYTE_HI:`CFG_UPPER_BYTE_LO] != 8'h00) begin
            upper_nonzero <= 1'b1;
        end
    end

    assign FLASH_REQ_O = (state == LOAD_READ);
    assign FLASH_ADDR_O = word_addr(idx);
    assign wr_en = (state == LOAD_CAPTURE);
    assign load_done = (state == LOAD_DONE);
    assign SYS_RST_N_O = load_done;

    cfg_shadow_mem #(
        .DEPTH(WORDS),
        .AW(`CFG_IDX_W),
        .DW(`CFG_WORD_W)
    ) u_shadow (
        .CLK_I(CLK_I),
        .RST_N_I(RST_N_I),
        .wr_en_i(wr_en),
        .wr_idx_i(idx),
        .wr_data_i(captured[`CFG_WORD_W-1:0]),
        .rd_idx_i(rd_idx),
        .rd_data_o(rd_word),
        .all_words_o(words)
    );

    assign sec_word = words[`IDX_SECURITY*`CFG_WORD_W +: `CFG_WORD_W];
    assign lim_word = words[`IDX_BOOT_LIMIT*`CFG_WORD_W +: `CFG_WORD_W];
    assign OSC_SELECT_O = words[`IDX_OSC_SELECT*`CFG_WORD_W +: `CFG_WORD_W];
    assign OSC_CONFIG_O = words[`IDX_OSC_CONFIG*`CFG_WORD_W +: `CFG_WORD_W];
    assign WATCHDOG_O = words[`IDX_WATCHDOG*`CFG_WORD_W +: `CFG_WORD_W];

    always_comb begin
        logic [2:0] f;
        f = sec_word[`SEC_CFG_LVL_HI:`SEC_CFG_LVL_LO];
        if (f == 3'b111) begin
            cfg_lvl = PROT_NONE;
        end else if (f == 3'b110) begin
            cfg_lvl = PROT_STANDARD;
        end else if (f[2]) begin
            cfg_lvl = PROT_ENHANCED;
        end else begin
            cfg_lvl = PROT_HIGH;
        end
    end

    assign gen_lvl = level2(sec_word[`SEC_GEN_LVL_HI:`SEC_GEN_LVL_LO]);
    assign boot_lvl = level2(sec_word[`SEC_BOOT_LVL_HI:`SEC_BOOT_LVL_LO]);
    assign CFG_PROT_LEVEL_O = cfg_lvl;
    assign GEN_PROT_LEVEL_O = gen_lvl;
    assign BOOT_PROT_LEVEL_O = boot_lvl;
    // blocks also asserted while loading so nothing writes before settings are known
    assign CFG_WRITE_BLOCK_O = !load_done || !sec_word[`SEC_CFG_WP];
    assign GEN_WRITE_BLOCK_O = !load_done || !sec_word[`SEC_GEN_WP];
    assign BOOT_WRITE_BLOCK_O = !load_done || !sec_word[`SEC_BOOT_WP];
    // limit all ones means an empty boot segment even when enabled
    assign BOOT_SEG_PRESENT_O = !sec_word[`SEC_BOOT_CTL] &&
        (lim_word[`BOOT_LIM_HI:0] != `BOOT_LIM_ALL_ONES);
    assign BOOT_SEG_END_PAGE_O = BOOT_SEG_PRESENT_O ? ~lim_word[`BOOT_LIM_HI:0] : '0;

    // apb slave: zero wait states, read data registered
    assign apb_access = PSEL_I && PENABLE_I;
    assign apb_wr = PSEL_I && !PENABLE_I && PWRITE_I;
    assign apb_rd = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign rd_shadow = PADDR_I < (`REG_SHADOW_BASE + 12'(WORDS * 4));
    assign rd_idx = PADDR_I[`CFG_IDX_W+1:2];

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            alt_vec_enable <= 1'b0;
        end else if (sec_word[`SEC_ALT_VEC_DIS]) begin
            alt_vec_enable <= 1'b0;
        end else if (apb_access && PWRITE_I && PADDR_I == `REG_ALT_VEC_CTRL) begin
            alt_vec_enable <= PWDATA_I[`ALT_CTRL_EN];
        end
    end
    assign ALT_VEC_ENABLE_O = alt_vec_enable;

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rd_shadow_q <= 1'b0;
            rd_other_q <= '0;
            err_q <= 1'b0;
        end else if (PSEL_I && !PENABLE_I) begin
            rd_shadow_q <= apb_rd && rd_shadow;
            err_q <= 1'b0;
            rd_other_q <= '0;
            if (apb_rd && PADDR_I == `REG_STATUS) begin
                rd_other_q[`REG_STATUS_DONE] <= load_done;
                rd_other_q[`REG_STATUS_UPPER_NZ] <= upper_nonzero;
            end else if (apb_rd && PADDR_I == `REG_ALT_VEC_CTRL) begin
                rd_other_q[`ALT_CTRL_EN] <= alt_vec_enable;
                rd_other_q[`ALT_CTRL_AVAIL] <= !sec_word[`SEC_ALT_VEC_DIS];
            end else if (apb_rd && PADDR_I == `REG_DECODE) begin
                rd_other_q[`DEC_INFO_HI:0] <= {BOOT_SEG_PRESENT_O, BOOT_SEG_END_PAGE_O};
                rd_other_q[`DEC_LVL_HI:`DEC_LVL_LO] <= {cfg_lvl, gen_lvl, boot_lvl};
            end else if (apb_rd && !rd_shadow) begin
                err_q <= 1'b1;
            end else if (apb_wr && PADDR_I != `REG_ALT_VEC_CTRL) begin
                err_q <= 1'b1;
            end
        end
    end

    assign PREADY_O = 1'b1;
    assign PSLVERR_O = apb_access && err_q;
    assign PRDATA_O = rd_shadow_q ? {16'h0000, rd_word} : rd_other_q;

    // a word is taken on the flash answer and stored on the following capture edge
    sequence word_taken_seq;
        FLASH_REQ_O && FLASH_ACK_I;
    endsequence
    sequence word_stored_seq;
        word_taken_seq ##1 wr_en;
    endsequence

    load_done_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        $rose(SYS_RST_N_O) |-> $past(state) == LOAD_CAPTURE && $past(idx) == `IDX_LAST)
        else $error("system released before last word loaded");
    release_sticks_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        SYS_RST_N_O |=> SYS_RST_N_O)
        else $error("system reset reasserted without device reset");
    fetch_store_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        word_stored_seq |=>
        words[$past(idx)*`CFG_WORD_W +: `CFG_WORD_W] == $past(captured[`CFG_WORD_W-1:0]))
        else $error("fetched word not stored");
    word_order_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        wr_en && idx != `IDX_LAST |=> idx == $past(idx) + 4'h1)
        else $error("words not loaded in turn");
    req_stops_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        load_done |-> !FLASH_REQ_O)
        else $error("flash read after load finished");
    addr_map_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        FLASH_REQ_O && idx == `IDX_SECURITY |-> FLASH_ADDR_O == `CFG_ADDR_SECURITY)
        else $error("security word fetched from wrong address");
    upper_flag_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        wr_en && captured[`CFG_UPPER_BYTE_HI:`CFG_UPPER_BYTE_LO] != 8'h00 |=> upper_nonzero)
        else $error("nonzero upper byte not flagged");
    alt_vec_off_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        sec_word[`SEC_ALT_VEC_DIS] |=> !ALT_VEC_ENABLE_O)
        else $error("alternate vectors enabled while disabled");
    alt_vec_write_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !sec_word[`SEC_ALT_VEC_DIS] && apb_access && PWRITE_I && PADDR_I == `REG_ALT_VEC_CTRL
        |=> ALT_VEC_ENABLE_O == $past(PWDATA_I[`ALT_CTRL_EN]))
        else $error("alternate vector enable not written");
    cfg_none_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        sec_word[`SEC_CFG_LVL_HI:`SEC_CFG_LVL_LO] == 3'b111 |-> CFG_PROT_LEVEL_O == PROT_NONE)
        else $error("config segment level not none");
    cfg_standard_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        sec_word[`SEC_CFG_LVL_HI:`SEC_CFG_LVL_LO] == 3'b110 |-> CFG_PROT_LEVEL_O == PROT_STANDARD)
        else $error("config segment level not standard");
    cfg_enhanced_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        sec_word[`SEC_CFG_LVL_HI -: 2] == 2'b10 |-> CFG_PROT_LEVEL_O == PROT_ENHANCED)
        else $error("config segment level not enhanced");
    cfg_level_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !sec_word[`SEC_CFG_LVL_HI] |-> CFG_PROT_LEVEL_O == PROT_HIGH)
        else $error("config segment level not high");
    cfg_wp_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        load_done |-> CFG_WRITE_BLOCK_O == !sec_word[`SEC_CFG_WP])
        else $error("config write block mismatch");
    load_block_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !load_done |-> CFG_WRITE_BLOCK_O && GEN_WRITE_BLOCK_O && BOOT_WRITE_BLOCK_O)
        else $error("segment writable before settings loaded");
    gen_level_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        sec_word[`SEC_GEN_LVL_HI:`SEC_GEN_LVL_LO] == 2'b10 |-> GEN_PROT_LEVEL_O == PROT_STANDARD)
        else $error("general segment level wrong");
    gen_high_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !sec_word[`SEC_GEN_LVL_HI] |-> GEN_PROT_LEVEL_O == PROT_HIGH)
        else $error("general segment level not high");
    gen_wp_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        load_done && !sec_word[`SEC_GEN_WP] |-> GEN_WRITE_BLOCK_O)
        else $error("general segment writable while protected");
    boot_seg_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        sec_word[`SEC_BOOT_CTL] || lim_word[12:0] == `BOOT_LIM_ALL_ONES |-> !BOOT_SEG_PRESENT_O)
        else $error("boot segment present when disabled or empty");
    boot_present_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !sec_word[`SEC_BOOT_CTL] && lim_word[`BOOT_LIM_HI:0] != `BOOT_LIM_ALL_ONES
        |-> BOOT_SEG_PRESENT_O)
        else $error("enabled boot segment missing");
    boot_page_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        BOOT_SEG_PRESENT_O |-> BOOT_SEG_END_PAGE_O == ~lim_word[`BOOT_LIM_HI:0])
        else $error("boot segment end page not inverted limit");
    boot_level_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        sec_word[`SEC_BOOT_LVL_HI:`SEC_BOOT_LVL_LO] == 2'b11 |-> BOOT_PROT_LEVEL_O == PROT_NONE)
        else $error("boot segment level wrong");
    boot_high_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !sec_word[`SEC_BOOT_LVL_HI] |-> BOOT_PROT_LEVEL_O == PROT_HIGH)
        else $error("boot segment level not high");
    boot_wp_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        load_done && !sec_word[`SEC_BOOT_WP] |-> BOOT_WRITE_BLOCK_O)
        else $error("boot segment writable while protected");
endmodule

// ==== src/cfg_loader_defines.svh ====
// Purpose: offsets, field positions and reset values for the configuration loader
// Assumes: flash word addresses are byte addresses of 24-bit program words
// Notes: definitions only
`ifndef CFG_LOADER_DEFINES_SVH
`define CFG_LOADER_DEFINES_SVH

`define CFG_WORD_COUNT 14
`define CFG_IDX_W 4
`define CFG_FLASH_AW 24
`define CFG_FLASH_DW 24
`define CFG_WORD_W 16

`define CFG_ADDR_SECURITY 24'h00af00
`define CFG_ADDR_BOOT_LIMIT 24'h00af10
`define CFG_ADDR_SIGNATURE 24'h00af14
`define CFG_ADDR_OSC_SELECT 24'h00af18
`define CFG_ADDR_OSC_CONFIG 24'h00af1c
`define CFG_ADDR_WATCHDOG 24'h00af20
`define CFG_ADDR_POWER_ON 24'h00af24
`define CFG_ADDR_DEBUG 24'h00af28
`define CFG_ADDR_DM_IVL_LO 24'h00af2c
`define CFG_ADDR_DM_IVL_HI 24'h00af30
`define CFG_ADDR_DM_CNT_LO 24'h00af34
`define CFG_ADDR_DM_CNT_HI 24'h00af38
`define CFG_ADDR_DEADMAN 24'h00af3c
`define CFG_ADDR_DEV_OPT 24'h00af40

// index of the words decoded by name, and of the last word, in the shadow array
`define IDX_SECURITY 4'h0
`define IDX_BOOT_LIMIT 4'h1
`define IDX_OSC_SELECT 4'h3
`define IDX_OSC_CONFIG 4'h4
`define IDX_WATCHDOG 4'h5
`define IDX_LAST 4'hd

// security word fields, then the boot limit word field
`define SEC_ALT_VEC_DIS 15
`define SEC_CFG_LVL_HI 11
`define SEC_CFG_LVL_LO 9
`define SEC_CFG_WP 8
`define SEC_GEN_LVL_HI 7
`define SEC_GEN_LVL_LO 6
`define SEC_GEN_WP 5
`define SEC_BOOT_CTL 3
`define SEC_BOOT_LVL_HI 2
`define SEC_BOOT_LVL_LO 1
`define SEC_BOOT_WP 0
`define BOOT_LIM_HI 12
`define BOOT_LIM_ALL_ONES 13'h1fff

// erased flash reads as all ones; shadow reset value
`define CFG_WORD_RESET 16'hffff
`define CFG_UPPER_BYTE_HI 23
`define CFG_UPPER_BYTE_LO 16

// apb register map, byte addresses
`define APB_AW 12
`define REG_SHADOW_BASE 12'h000
`define REG_STATUS 12'h040
`define REG_ALT_VEC_CTRL 12'h044
`define REG_DECODE 12'h048
`define REG_STATUS_DONE 0
`define REG_STATUS_UPPER_NZ 1
`define ALT_CTRL_EN 0
`define ALT_CTRL_AVAIL 1
`define DEC_INFO_HI 13
`define DEC_LVL_HI 21
`define DEC_LVL_LO 16

`endif

// ==== src/cfg_loader_pkg.sv ====
// Purpose: types shared by the configuration loader
// Assumes: nothing beyond the defines header
// Notes: protection levels ordered from weakest to strongest
package cfg_loader_pkg;
    typedef enum logic [1:0] {
        PROT_NONE = 2'b00,
        PROT_STANDARD = 2'b01,
        PROT_ENHANCED = 2'b10,
        PROT_HIGH = 2'b11
    } prot_level_type;

    typedef enum logic [1:0] {
        LOAD_IDLE = 2'b00,
        LOAD_READ = 2'b01,
        LOAD_CAPTURE = 2'b10,
        LOAD_DONE = 2'b11
    } load_state_type;
endpackage

// ==== src/cfg_shadow_mem.sv ====
// Purpose: shadow store for the configuration words
// Assumes: one write port, one registered read port
// Notes: contents return to erased value on every reset
`timescale 1ns/1ns
`include "cfg_loader_defines.svh"
module cfg_shadow_mem #(
    parameter int DEPTH = `CFG_WORD_COUNT,
    parameter int AW = `CFG_IDX_W,
    parameter int DW = `CFG_WORD_W
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_idx_i,
    input wire logic [DW-1:0] wr_data_i,
    input wire logic [AW-1:0] rd_idx_i,
    output logic [DW-1:0] rd_data_o,
    output logic [DEPTH*DW-1:0] all_words_o
);
    logic [DW-1:0] mem [DEPTH];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : gen_word
            always_ff @(posedge CLK_I or negedge RST_N_I) begin
                if (!RST_N_I) begin
                    mem[g] <= `CFG_WORD_RESET;
                end else if (wr_en_i && (wr_idx_i == AW'(g))) begin
                    mem[g] <= wr_data_i;
                end
            end
            assign all_words_o[g*DW +: DW] = mem[g];
        end
    endgenerate

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rd_data_o <= '0;
        end else if (int'(rd_idx_i) < DEPTH) begin
            rd_data_o <= mem[rd_idx_i];
        end else begin
            rd_data_o <= '0;
        end
    end
endmodule

// ==== testbench/cfg_flash_model.sv ====
// Purpose: program flash holding the configuration words, read port only
// Assumes: one word per request, ack pulses for one cycle
// Notes: data bus is scrambled every cycle outside the ack cycle
`timescale 1ns/1ns
`include "cfg_loader_defines.svh"
module cfg_flash_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic [`CFG_FLASH_AW-1:0] addr_i,
    input wire logic [`CFG_WORD_W-1:0] sec_word_i,
    input wire logic [`CFG_WORD_W-1:0] lim_word_i,
    input wire logic [7:0] upper_i,
    input wire logic [3:0] delay_i,
    output logic ack_o,
    output logic [`CFG_FLASH_DW-1:0] rdata_o
);
    logic [3:0] wait_cnt;
    logic [`CFG_WORD_W-1:0] word;

    // top page: security, boot limit, then filler words keyed by address
    assign word = (addr_i == `CFG_ADDR_SECURITY) ? sec_word_i :
        (addr_i == `CFG_ADDR_BOOT_LIMIT) ? lim_word_i : {8'ha5, addr_i[7:0]};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_o <= 1'b0;
            wait_cnt <= 4'h0;
            rdata_o <= 24'h000000;
        end else if (req_i && !ack_o && wait_cnt >= delay_i) begin
            ack_o <= 1'b1;
            // upper byte zero unless a scenario asks otherwise
            rdata_o <= {upper_i, word};
            wait_cnt <= 4'h0;
        end else begin
            ack_o <= 1'b0;
            wait_cnt <= (req_i && !ack_o) ? wait_cnt + 4'h1 : 4'h0;
            // stale data must not look valid
            rdata_o <= ~rdata_o;
        end
    end
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for the configuration word loader
// Assumes: apb slave answers with zero wait, flash model beside it
// Notes: every load restarts from a full reset
`timescale 1ns/1ns
`include "cfg_loader_defines.svh"
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic req, ack, sys_rst_n, alt_en, cwb, gwb, bwb, present, pready, pslverr, er;
    logic [23:0] addr, rdata;
    logic [15:0] osc_sel, osc_cfg, wdt, sec = 16'hffff, lim = 16'h1fff;
    logic [1:0] clvl, glvl, blvl;
    logic [12:0] endp;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] upper = 8'h00;
    logic [3:0] delay = 4'h0;
    logic [23:0] alog [$];
    int fail_count = 0, total_checks = 0;

    always #5 clk = ~clk;
    always @(posedge clk) if (req && ack) alog.push_back(addr);

    cfg_word_loader u_cfg_word_loader (.CLK_I(clk), .RST_N_I(rst_n), .FLASH_REQ_O(req),
        .FLASH_ADDR_O(addr), .FLASH_ACK_I(ack), .FLASH_RDATA_I(rdata), .SYS_RST_N_O(sys_rst_n),
        .OSC_SELECT_O(osc_sel), .OSC_CONFIG_O(osc_cfg), .WATCHDOG_O(wdt),
        .ALT_VEC_ENABLE_O(alt_en), .CFG_WRITE_BLOCK_O(cwb), .GEN_WRITE_BLOCK_O(gwb),
        .BOOT_WRITE_BLOCK_O(bwb), .CFG_PROT_LEVEL_O(clvl), .GEN_PROT_LEVEL_O(glvl),
        .BOOT_PROT_LEVEL_O(blvl), .BOOT_SEG_PRESENT_O(present), .BOOT_SEG_END_PAGE_O(endp),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));
    cfg_flash_model u_cfg_flash_model (.clk_i(clk), .rst_n_i(rst_n), .req_i(req),
        .addr_i(addr), .sec_word_i(sec), .lim_word_i(lim), .upper_i(upper),
        .delay_i(delay), .ack_o(ack), .rdata_o(rdata));

    function automatic logic [23:0] ea(int i);
        return i == 0 ? 24'haf00 : 24'haf10 + 24'(4 * (i - 1));
    endfunction
    function automatic logic [15:0] ew(int i);
        return i == 0 ? sec : i == 1 ? lim : {8'ha5, 8'h10 + 8'(4 * (i - 1))};
    endfunction

    task summarize;
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task hang;
        fail_count++;
        summarize();
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) hang();
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task load(input logic [15:0] s, input logic [15:0] l, input logic [7:0] u,
        input logic [3:0] dl);
        int n;
        @(posedge clk);
        rst_n <= 1'b0;
        sec <= s;
        lim <= l;
        upper <= u;
        delay <= dl;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        alog.delete();
        repeat (2) @(posedge clk);
        chk(32'(sys_rst_n), 32'h0);
        chk(32'({cwb, gwb, bwb}), 32'h7);
        n = 0;
        while (sys_rst_n !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 2000) hang();
        end
        chk(32'(alog.size()), 32'd14);
        foreach (alog[i]) chk({8'h00, alog[i]}, {8'h00, ea(i)});
    endtask

    task check_words;
        for (int i = 0; i < 14; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk(rd, {16'h0, ew(i)});
        end
        chk({osc_sel, osc_cfg}, {ew(3), ew(4)});
        chk({16'h0, wdt}, {16'h0, ew(5)});
    endtask

    task check_decode;
        logic [1:0] c, g, b;
        logic p;
        logic [12:0] e;
        c = sec[11:9] == 3'b111 ? 2'd0 : sec[11:9] == 3'b110 ? 2'd1 : sec[11] ? 2'd2 : 2'd3;
        g = sec[7:6] == 2'b11 ? 2'd0 : sec[7:6] == 2'b10 ? 2'd1 : 2'd3;
        b = sec[2:1] == 2'b11 ? 2'd0 : sec[2:1] == 2'b10 ? 2'd1 : 2'd3;
        p = !sec[3] && lim[12:0] != 13'h1fff;
        e = p ? ~lim[12:0] : 13'h0;
        chk(32'(clvl), 32'(c));
        chk(32'(glvl), 32'(g));
        chk(32'(blvl), 32'(b));
        chk(32'({cwb, gwb, bwb}), 32'({!sec[8], !sec[5], !sec[0]}));
        chk(32'(present), 32'(p));
        chk(32'(endp), 32'(e));
        apb(1'b0, 12'h048, 32'h0);
        chk(rd, {10'h0, c, g, b, 2'b00, p, e});
    endtask

    task sweep;
        logic [2:0] v;
        for (int k = 0; k < 8; k++) begin
            v = 3'(k);
            load({v[2], 3'b000, v, v[0], 2'(v), v[1], 1'b0, v[1] ^ v[0], 2'(v + 3'h1), v[2]},
                k == 3 ? 16'h1fff : 16'h1ff0 - 16'(k), 8'h00, 4'(k % 3));
            check_decode();
        end
    endtask

    task alt_vector;
        load(16'h7fff, 16'h1fff, 8'h00, 4'h1);
        apb(1'b1, 12'h044, 32'h1);
        apb(1'b0, 12'h044, 32'h0);
        chk(rd, 32'h3);
        chk(32'(alt_en), 32'h1);
        load(16'hffff, 16'h1fff, 8'h00, 4'h0);
        apb(1'b1, 12'h044, 32'h1);
        apb(1'b0, 12'h044, 32'h0);
        chk(rd, 32'h0);
        chk(32'(alt_en), 32'h0);
    endtask

    task refusal;
        apb(1'b0, 12'h04c, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'b1, 12'h000, 32'h1234);
        chk(32'(er), 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, {16'h0, ew(0)});
        apb(1'b0, 12'h040, 32'h0);
        chk(rd, 32'h1);
    endtask

    task mid_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        sec <= 16'h0000;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        chk(32'(sys_rst_n), 32'h0);
        // aborted load must be thrown away by the next reset
        load(16'h81c6, 16'h1e00, 8'h00, 4'h2);
        check_decode();
        check_words();
    endtask

    task upper_slow;
        load(16'h5a69, 16'h1ffe, 8'h5a, 4'h7);
        check_words();
        check_decode();
        apb(1'b0, 12'h040, 32'h0);
        chk(rd, 32'h3);
    endtask

    initial begin
        load(16'hffff, 16'h1fff, 8'h00, 4'h0);
        check_words();
        check_decode();
        sweep();
        alt_vector();
        refusal();
        mid_reset();
        upper_slow();
        summarize();
    end
endmodule
